//--- common/clc_pkg.sv
// Package: constants, code table and state types of the cell line coder
// Functional notes
// - Transmit: scramble, then 4b5b, then NRZI
// - Nibble to symbol through fixed table
// - Sixteen data symbols plus unique escape
// - Escape pairs: two start-of-cell, one marker
// - Idle line always carries valid symbols
// - Start pair then cell, no gap
// - Timing reference fall inserts marker pair
// - Receiver finds pairs, stores cells in FIFO
// - Framing locks on any valid symbols
// - Lock machine drives good-signal status
// - Signal loss clears good, disables FIFO
// - Fast mode differs only in bit rate
// - Reference clock plus control bit pick rate
// - Each FIFO holds three cells
// - Address latched on address-strobe fall
// - Read strobe and select make device drive
// - Write data taken when write ends
// - Eight-bit shared address/data register port
// - Eight-bit cell bus toward ATM layer
// - Marker output and activity indicator outputs
// - Active-low asynchronous reset clears all state but FIFO storage; scramblers load their seed
// - Interrupt held low until status read
package clc_pkg;
	localparam int CLK_KHZ = 100000;
	localparam int RATE_KBPS = 25600;
	localparam int RATE_STEP_KHZ = 800;
	localparam logic [7:0] BIT_INC = 8'(RATE_KBPS / RATE_STEP_KHZ);
	localparam logic [7:0] BIT_MOD = 8'(CLK_KHZ / RATE_STEP_KHZ);
	localparam int CELL_BYTES = 53;
	localparam int CELL_NIBS = 2 * CELL_BYTES;
	localparam int FIFO_CELLS = 3;
	localparam int UTP_AW = 5;
	localparam logic [4:0] SYM_ESC = 5'h1F;
	localparam logic [3:0] CMD_SOC_A = 4'h0;
	localparam logic [3:0] CMD_SOC_B = 4'hF;
	localparam logic [3:0] CMD_MARK = 4'h8;
	localparam logic [9:0] LFSR_SEED = 10'h3FF;
	localparam int LOCK_SYMS = 16;
	localparam int LOSS_SYMS = 4;
	localparam int LOS_TIMEOUT_NS = 2000;
	localparam int LOS_TIMEOUT_CYC = LOS_TIMEOUT_NS * (CLK_KHZ / 1000) / 1000;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_INT_STAT = 8'h02;
	localparam logic [7:0] REG_INT_MASK = 8'h03;
	localparam logic [7:0] REG_UTP_ADDR = 8'h04;
	localparam int CTRL_RATE51 = 0;
	localparam int INT_PARITY = 0;
	localparam int INT_LOS = 1;
	localparam int INT_MARK = 2;
	localparam int INT_OVF = 3;
	// No data symbol has two leading or two trailing ones, so no pair forms the escape
	localparam logic [4:0] SYM_TAB [16] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h08, 5'h09,
		5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h14, 5'h15, 5'h16};

	function automatic logic [4:0] clc_dec(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (SYM_TAB[i] == s) begin
				r = {1'h1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [9:0] clc_lfsr4(input logic [9:0] s);
		logic [9:0] r;
		r = s;
		for (int i = 0; i < 4; i++) begin
			r = {r[8:0], r[9] ^ r[6]};
		end
		return r;
	endfunction

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_CMD = 2'b01, TX_CELL = 2'b10} clc_tx_e;

	typedef struct packed {
		logic [7:0] acc;
		logic bit_en;
		logic tx_line;
		logic [4:0] tx_sh;
		logic [2:0] tx_cnt;
		clc_tx_e tx_st;
		logic cmd_soc;
		logic [6:0] nib_cnt;
		logic nib_lo;
		logic [9:0] tx_lfsr;
		logic mark_pend;
		logic ref_q;
		logic rx_prev;
		logic [3:0] rx_sh;
		logic [2:0] rx_cnt;
		logic [4:0] lock_cnt;
		logic [2:0] err_cnt;
		logic good;
		logic [7:0] los_cnt;
		logic rx_esc;
		logic rx_in_cell;
		logic [6:0] rx_nib_cnt;
		logic [3:0] rx_hi;
		logic [9:0] rx_lfsr;
		logic rx_push;
		logic [7:0] rx_byte;
		logic mark_out;
		logic [7:0] rx_data;
		logic rx_soc;
		logic rx_par;
		logic [5:0] rx_bcnt;
		logic ale_q;
		logic wr_q;
		logic rd_q;
		logic [7:0] wr_data;
		logic [7:0] reg_addr;
		logic [7:0] ctrl;
		logic [3:0] int_stat;
		logic [3:0] int_mask;
		logic [UTP_AW-1:0] utp_addr;
		logic [7:0] ad_out;
	} clc_state_s;
endpackage

//--- core/clc_line_coder.sv
// Cell line coder: cell FIFO and transmission-convergence top
`timescale 1ns/1ns

module clc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 159
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	import clc_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	// Handshakes straight from the fill count
	assign in_ready = count != CW'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap at DEPTH, so a depth of three cells needs no power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'h1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'h1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// Storage carries no reset
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	fifo_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!flush && push && !pop) |=> count == $past(count) + 1'h1)
		else $error("fifo count did not follow a push");
endmodule // clc_fifo

module clc_line_coder (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_ref_64mhz,
	output logic tx_line_out,
	input wire logic rx_line_in,
	input wire logic rx_bit_en,
	input wire logic tx_timing_ref_in,
	output logic rx_marker_out,
	output logic good_signal,
	output logic tx_led,
	output logic rx_led,
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic ad_oe,
	input wire logic ale,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic int_n_out,
	output logic int_n_oe,
	input wire logic [clc_pkg::UTP_AW-1:0] tx_addr,
	input wire logic tx_enb_n,
	input wire logic [7:0] tx_data,
	input wire logic tx_parity,
	output logic tx_clav,
	output logic tx_clav_oe,
	input wire logic [clc_pkg::UTP_AW-1:0] rx_addr,
	input wire logic rx_enb_n,
	output logic [7:0] rx_data,
	output logic rx_soc,
	output logic rx_parity,
	output logic rx_clav,
	output logic rx_clav_oe
);
	import clc_pkg::*;
	localparam int DEPTH = FIFO_CELLS * CELL_BYTES;
	localparam int CW = $clog2(DEPTH+1);
	clc_state_s q;
	clc_state_s next_q;
	logic rate51;
	logic wr_act;
	logic rd_act;
	logic tx_wr;
	logic tx_in_ready;
	logic tx_out_valid;
	logic [7:0] tx_head;
	logic [CW-1:0] tx_count;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [7:0] rx_head;
	logic [CW-1:0] rx_count;
	logic rx_rd;
	logic sym_load;
	logic tx_pop;
	logic rx_lost;
	logic [3:0] int_set;

	// Software bit forces nothing slower than the reference allows
	assign rate51 = q.ctrl[CTRL_RATE51] | line_ref_64mhz;
	assign wr_act = ~wr_n & ~cs_n;
	assign rd_act = ~rd_n & ~cs_n;
	assign tx_wr = ~tx_enb_n & (tx_addr == q.utp_addr);
	assign rx_rd = ~rx_enb_n & (rx_addr == q.utp_addr) & rx_out_valid;

	// Cell buses: availability pins only driven when this port is addressed
	assign tx_clav = (CW'(DEPTH) - tx_count) >= CW'(CELL_BYTES);
	assign tx_clav_oe = tx_addr == q.utp_addr;
	assign rx_clav = rx_count >= CW'(CELL_BYTES);
	assign rx_clav_oe = rx_addr == q.utp_addr;
	assign rx_data = q.rx_data;
	assign rx_soc = q.rx_soc;
	assign rx_parity = q.rx_par;

	// Pins from state; register port drives only during a read
	assign tx_line_out = q.tx_line;
	assign good_signal = q.good;
	assign rx_marker_out = q.mark_out;
	assign tx_led = q.tx_st == TX_CELL;
	assign rx_led = q.rx_in_cell;
	assign ad_out = q.ad_out;
	assign ad_oe = rd_act & ~ale;
	assign int_n_out = 1'h0;
	assign int_n_oe = |(q.int_stat & q.int_mask);

	clc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(1'h0),
		.in_valid(tx_wr),
		.in_ready(tx_in_ready),
		.in_data(tx_data),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_head),
		.count(tx_count)
	);

	// A lost signal holds the receive FIFO flushed
	clc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(~q.good),
		.in_valid(q.rx_push),
		.in_ready(rx_in_ready),
		.in_data(q.rx_byte),
		.out_valid(rx_out_valid),
		.out_ready(rx_rd),
		.out_data(rx_head),
		.count(rx_count)
	);

	// Whole next state: divider, transmitter, receiver, register port
	always_comb begin
		logic [7:0] sum;
		logic [4:0] sym;
		logic [4:0] dec;
		logic [3:0] nib;
		logic rbit;
		next_q = q;
		sum = q.acc + (rate51 ? {BIT_INC[6:0], 1'h0} : BIT_INC);
		sym = 5'h00;
		dec = 5'h00;
		nib = 4'h0;
		rbit = rx_line_in ^ q.rx_prev;
		sym_load = 1'h0;
		tx_pop = 1'h0;
		rx_lost = 1'h0;
		int_set = 4'h0;
		next_q.bit_en = sum >= BIT_MOD;
		next_q.acc = (sum >= BIT_MOD) ? sum - BIT_MOD : sum;
		next_q.rx_push = 1'h0;
		next_q.mark_out = 1'h0;
		next_q.ref_q = tx_timing_ref_in;
		if (q.ref_q && !tx_timing_ref_in) begin
			next_q.mark_pend = 1'h1;
		end
		if (tx_wr && tx_in_ready && !(^{tx_data, tx_parity})) begin
			int_set[INT_PARITY] = 1'h1;
		end
		// Transmit: one line bit per divider pulse, symbol chosen at its boundary
		if (q.bit_en) begin
			if (q.tx_sh[4]) begin
				next_q.tx_line = ~q.tx_line;
			end
			next_q.tx_sh = {q.tx_sh[3:0], 1'h0};
			next_q.tx_cnt = q.tx_cnt + 3'h1;
			if (q.tx_cnt == 3'h4) begin
				sym_load = 1'h1;
				next_q.tx_cnt = 3'h0;
				case (q.tx_st)
					TX_IDLE: begin
						next_q.tx_lfsr = clc_lfsr4(q.tx_lfsr);
						sym = SYM_TAB[q.tx_lfsr[3:0]];
						if (q.mark_pend) begin
							next_q.tx_st = TX_CMD;
							next_q.cmd_soc = 1'h0;
							sym = SYM_ESC;
						end else if (tx_count >= CW'(CELL_BYTES)) begin
							next_q.tx_st = TX_CMD;
							next_q.cmd_soc = 1'h1;
							sym = SYM_ESC;
						end
					end
					TX_CMD: begin
						sym = SYM_TAB[q.cmd_soc ? CMD_SOC_A : CMD_MARK];
						next_q.tx_st = q.cmd_soc ? TX_CELL : TX_IDLE;
						next_q.nib_cnt = 7'h00;
						next_q.nib_lo = 1'h0;
						next_q.tx_lfsr = LFSR_SEED;
						if (!q.cmd_soc && !(q.ref_q && !tx_timing_ref_in)) begin
							next_q.mark_pend = 1'h0;
						end
					end
					TX_CELL: begin
						nib = q.nib_lo ? tx_head[3:0] : tx_head[7:4];
						sym = SYM_TAB[nib ^ q.tx_lfsr[3:0]];
						next_q.tx_lfsr = clc_lfsr4(q.tx_lfsr);
						tx_pop = q.nib_lo;
						next_q.nib_lo = ~q.nib_lo;
						next_q.nib_cnt = q.nib_cnt + 7'h01;
						if (q.nib_cnt == 7'(CELL_NIBS-1)) begin
							next_q.tx_st = TX_IDLE;
						end
					end
					default: begin
						next_q.tx_st = TX_IDLE;
					end
				endcase
				next_q.tx_sh = sym;
			end
		end
		// Receive: a bad symbol while hunting slips the window by one bit
		if (rx_bit_en) begin
			next_q.rx_prev = rx_line_in;
			next_q.rx_sh = {q.rx_sh[2:0], rbit};
			next_q.rx_cnt = q.rx_cnt + 3'h1;
			next_q.los_cnt = 8'h00;
			if (q.rx_cnt == 3'h4) begin
				next_q.rx_cnt = 3'h0;
				dec = clc_dec({q.rx_sh, rbit});
				if (!dec[4] && {q.rx_sh, rbit} != SYM_ESC) begin
					if (!q.good) begin
						next_q.rx_cnt = 3'h4;
						next_q.lock_cnt = 5'h00;
					end else if (q.err_cnt == 3'(LOSS_SYMS-1)) begin
						rx_lost = 1'h1;
					end else begin
						next_q.err_cnt = q.err_cnt + 3'h1;
					end
				end else begin
					next_q.err_cnt = 3'h0;
					if (!q.good) begin
						next_q.lock_cnt = q.lock_cnt + 5'h01;
						next_q.good = q.lock_cnt == 5'(LOCK_SYMS-1);
					end else if (!dec[4]) begin
						next_q.rx_esc = 1'h1;
						next_q.rx_in_cell = 1'h0;
					end else if (q.rx_esc) begin
						next_q.rx_esc = 1'h0;
						if (dec[3:0] == CMD_SOC_A || dec[3:0] == CMD_SOC_B) begin
							next_q.rx_in_cell = 1'h1;
							next_q.rx_nib_cnt = 7'h00;
							next_q.rx_lfsr = LFSR_SEED;
						end else if (dec[3:0] == CMD_MARK) begin
							next_q.mark_out = 1'h1;
							int_set[INT_MARK] = 1'h1;
						end
					end else if (q.rx_in_cell) begin
						nib = dec[3:0] ^ q.rx_lfsr[3:0];
						next_q.rx_lfsr = clc_lfsr4(q.rx_lfsr);
						next_q.rx_nib_cnt = q.rx_nib_cnt + 7'h01;
						next_q.rx_hi = nib;
						if (q.rx_nib_cnt[0]) begin
							next_q.rx_push = 1'h1;
							next_q.rx_byte = {q.rx_hi, nib};
						end
						if (q.rx_nib_cnt == 7'(CELL_NIBS-1)) begin
							next_q.rx_in_cell = 1'h0;
						end
					end
				end
			end
		end else if (q.good) begin
			next_q.los_cnt = q.los_cnt + 8'h01;
			rx_lost = q.los_cnt == 8'(LOS_TIMEOUT_CYC-1);
		end
		if (rx_lost) begin
			next_q.good = 1'h0;
			next_q.lock_cnt = 5'h00;
			next_q.err_cnt = 3'h0;
			next_q.rx_esc = 1'h0;
			next_q.rx_in_cell = 1'h0;
			next_q.rx_push = 1'h0;
			int_set[INT_LOS] = 1'h1;
		end
		if (q.rx_push && !rx_in_ready) begin
			int_set[INT_OVF] = 1'h1;
		end
		// Cell bus read: first byte of each cell flagged, odd parity
		if (rx_rd) begin
			next_q.rx_data = rx_head;
			next_q.rx_soc = q.rx_bcnt == 6'h00;
			next_q.rx_par = ~(^rx_head);
			next_q.rx_bcnt = (q.rx_bcnt == 6'(CELL_BYTES-1)) ? 6'h00 : q.rx_bcnt + 6'h01;
		end
		if (!q.good) begin
			next_q.rx_bcnt = 6'h00;
		end
		// Register port: strobes sampled as plain levels, edges found here
		next_q.ale_q = ale;
		next_q.wr_q = wr_act;
		next_q.rd_q = rd_act;
		if (q.ale_q && !ale) begin
			next_q.reg_addr = ad_in;
		end
		if (wr_act) begin
			next_q.wr_data = ad_in;
		end
		if (q.wr_q && !wr_act) begin
			case (q.reg_addr)
				REG_CTRL: next_q.ctrl = q.wr_data;
				REG_INT_MASK: next_q.int_mask = q.wr_data[3:0];
				REG_UTP_ADDR: next_q.utp_addr = q.wr_data[UTP_AW-1:0];
				default: next_q.ctrl = q.ctrl;
			endcase
		end
		case (q.reg_addr)
			REG_CTRL: next_q.ad_out = q.ctrl;
			REG_STATUS: next_q.ad_out = {6'h00, rate51, q.good};
			REG_INT_STAT: next_q.ad_out = {4'h0, q.int_stat};
			REG_INT_MASK: next_q.ad_out = {4'h0, q.int_mask};
			REG_UTP_ADDR: next_q.ad_out = {3'h0, q.utp_addr};
			default: next_q.ad_out = 8'h00;
		endcase
		// Only bits the host was shown are cleared, and a new event still wins
		next_q.int_stat = q.int_stat | int_set;
		if (q.rd_q && !rd_act && q.reg_addr == REG_INT_STAT) begin
			next_q.int_stat = (q.int_stat & ~q.ad_out[3:0]) | int_set;
		end
	end

	// One state register, asynchronous active-low clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.tx_lfsr <= LFSR_SEED;
			q.rx_lfsr <= LFSR_SEED;
		end else begin
			q <= next_q;
		end
	end

	nrzi_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(q.bit_en && q.tx_sh[4]) |=> tx_line_out != $past(tx_line_out))
		else $error("line did not toggle on a one bit");
	sym_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
		sym_load |=> (clc_dec(q.tx_sh) != 5'h00 || q.tx_sh == SYM_ESC))
		else $error("transmitted symbol outside the code set");
	soc_gapless_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sym_load && q.tx_st == TX_CMD && q.cmd_soc) |=> q.tx_st == TX_CELL && q.nib_cnt == 7'h00)
		else $error("cell did not follow start pair");
	marker_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
		(q.ref_q && !tx_timing_ref_in) |=> q.mark_pend)
		else $error("timing reference fall not recorded");
	lock_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(q.good) |-> $past(q.lock_cnt) == 5'(LOCK_SYMS-1))
		else $error("good signal without full lock count");
	loss_flush_a: assert property (@(posedge clk) disable iff (!rst_n)
		rx_lost |=> !good_signal ##1 (rx_count == '0 && !rx_clav))
		else $error("receive FIFO live after signal loss");
	rate_force_a: assert property (@(posedge clk) disable iff (!rst_n)
		(line_ref_64mhz && !q.bit_en) |=> ($past(q.acc) + 8'h40 >= BIT_MOD) == q.bit_en)
		else $error("fast reference did not select double rate");
	addr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		(q.ale_q && !ale) |=> q.reg_addr == $past(ad_in))
		else $error("address not latched on strobe fall");
	write_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		(q.wr_q && !wr_act && q.reg_addr == REG_INT_MASK) |=> q.int_mask == $past(q.wr_data[3:0]))
		else $error("write data not taken at end of write");
	int_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(int_n_oe && !(q.rd_q && !rd_act)) |=> int_n_oe)
		else $error("interrupt released without a status read");
endmodule // clc_line_coder

//--- verif/clc_peer_model.sv
// Peer transceiver model: recovers bits from our line and loops them back
`timescale 1ns/1ns

module clc_peer_model (
	input wire logic clk,
	input wire logic tx_line,
	input wire logic fast,
	input wire logic mute,
	output logic rx_line,
	output logic rx_bit_en
);
	logic [7:0] acc = 8'h00;
	logic last = 1'b0;
	logic [7:0] step;
	logic [7:0] snap;

	// Same fractional rate as the sender, doubled in the fast mode
	assign step = fast ? 8'h40 : 8'h20;
	// Fast bits last one or two clocks, so the sample point sits earlier after an edge
	assign snap = fast ? 8'h8C : 8'h3D;

	// Phase snaps to each line edge so sampling lands mid-bit
	always @(posedge clk) begin
		last <= tx_line;
		rx_bit_en <= 1'b0;
		if (mute) begin
			rx_line <= ~rx_line; // Released line: toggles so no stale level looks valid
		end else if (tx_line != last) begin
			acc <= snap;
			if (acc >= 8'h7D) begin
				rx_bit_en <= 1'b1; // One-clock bit still owed its sample
				rx_line <= last;
			end
		end else if (acc + step >= 8'h7D) begin
			acc <= acc + step - 8'h7D;
			rx_bit_en <= 1'b1;
			rx_line <= tx_line;
		end else begin
			acc <= acc + step;
		end
	end

	initial begin
		rx_line = 1'b0;
		rx_bit_en = 1'b0;
	end
endmodule // clc_peer_model

//--- verif/tb_clc_line_coder.sv
// Testbench: line loopback through the peer model, cell, marker and register checks
`timescale 1ns/1ns

module tb_clc_line_coder;
	import clc_pkg::*;
	logic clk, rst_n, ref64, rx_line, rx_bit_en, tx_ref, marker, good, tx_led, rx_led;
	logic tx_line, ad_oe, ale, cs_n, rd_n, wr_n, int_n_out, int_n_oe, int_line;
	logic [7:0] ad_in, ad_out, host_ad, tx_data, rx_data;
	logic [UTP_AW-1:0] tx_addr, rx_addr;
	logic tx_enb_n, tx_parity, tx_clav, tx_clav_oe, rx_enb_n, rx_soc, rx_parity;
	logic rx_clav, rx_clav_oe, fast, mute, led_q;
	int miscompares, comparisons, cyc, marks, cells;
	logic [7:0] v;

	// Shared bus wire: device drives it while reading; interrupt line is pulled up
	assign ad_in = ad_oe ? ad_out : host_ad;
	assign int_line = int_n_oe ? int_n_out : 1'b1;

	clc_line_coder clc_line_coder_i (.clk(clk), .rst_n(rst_n), .line_ref_64mhz(ref64),
		.tx_line_out(tx_line), .rx_line_in(rx_line), .rx_bit_en(rx_bit_en),
		.tx_timing_ref_in(tx_ref), .rx_marker_out(marker), .good_signal(good),
		.tx_led(tx_led), .rx_led(rx_led), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
		.ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .int_n_out(int_n_out),
		.int_n_oe(int_n_oe), .tx_addr(tx_addr), .tx_enb_n(tx_enb_n), .tx_data(tx_data),
		.tx_parity(tx_parity), .tx_clav(tx_clav), .tx_clav_oe(tx_clav_oe),
		.rx_addr(rx_addr), .rx_enb_n(rx_enb_n), .rx_data(rx_data), .rx_soc(rx_soc),
		.rx_parity(rx_parity), .rx_clav(rx_clav), .rx_clav_oe(rx_clav_oe));

	clc_peer_model clc_peer_model_i (.clk(clk), .tx_line(tx_line), .fast(fast),
		.mute(mute), .rx_line(rx_line), .rx_bit_en(rx_bit_en));

	always #5 clk = ~clk;

	// Event counters and the hang guard; ceiling well above the longest scenario
	always @(posedge clk) begin
		cyc <= cyc + 1;
		led_q <= rx_led;
		if (marker === 1'b1) marks <= marks + 1;
		if (led_q === 1'b1 && rx_led === 1'b0) cells <= cells + 1;
		if (cyc == 60000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] cbyte(input int k, input int i);
		return 8'(k * 16 + i * 3);
	endfunction

	// Address phase, then data under write strobe; released one cycle later
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		ale = 1'b1;
		host_ad = a;
		tick(1);
		ale = 1'b0;
		tick(1);
		host_ad = d;
		wr_n = 1'b0;
		cs_n = 1'b0;
		tick(1);
		wr_n = 1'b1;
		cs_n = 1'b1;
		tick(2);
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		ale = 1'b1;
		host_ad = a;
		tick(1);
		ale = 1'b0;
		tick(1);
		rd_n = 1'b0;
		cs_n = 1'b0;
		tick(2);
		d = ad_out;
		check(8'(ad_oe), 8'h01);
		rd_n = 1'b1;
		cs_n = 1'b1;
		tick(1);
	endtask

	// One cell of 53 bytes, back to back; optional parity fault on the first byte
	task automatic send_cell(input int k, input bit bad);
		for (int i = 0; i < CELL_BYTES; i++) begin
			tx_enb_n = 1'b0;
			tx_data = cbyte(k, i);
			tx_parity = ~^cbyte(k, i) ^ (bad && i == 0);
			tick(1);
		end
		tx_enb_n = 1'b1;
		tick(1);
	endtask

	task automatic recv_cell(input int k);
		for (int i = 0; i < CELL_BYTES; i++) begin
			rx_enb_n = 1'b0;
			tick(1);
			rx_enb_n = 1'b1;
			tick(1);
			check(rx_data, cbyte(k, i));
			check(8'(rx_soc), 8'(i == 0));
			check(8'(rx_parity), 8'(~^cbyte(k, i)));
		end
	endtask

	task automatic wait_good(input logic lvl);
		for (int n = 0; n < 3000 && good !== lvl; n++) tick(1);
		check(8'(good), 8'(lvl));
	endtask

	task automatic t_reset();
		check(8'(good), 8'h00);
		check({6'h00, tx_clav, tx_clav_oe}, 8'h03);
		check({6'h00, rx_clav, int_n_oe}, 8'h00);
		wait_good(1'b1);
	endtask

	task automatic t_regs();
		reg_write(REG_CTRL, 8'h00);
		reg_read(REG_CTRL, v);
		check(v, 8'h00);
		reg_write(REG_INT_MASK, 8'h04);
		reg_read(REG_INT_MASK, v);
		check(v, 8'h04);
		reg_write(REG_STATUS, 8'hFE);
		reg_read(REG_STATUS, v);
		check(v, 8'h01);
		reg_read(8'h1F, v);
		check(v, 8'h00);
		reg_write(REG_UTP_ADDR, 8'h05);
		check({6'h00, tx_clav_oe, rx_clav_oe}, 8'h00);
		reg_read(REG_UTP_ADDR, v);
		check(v, 8'h05);
		reg_write(REG_UTP_ADDR, 8'h00);
		check({6'h00, tx_clav_oe, rx_clav_oe}, 8'h03);
	endtask

	// Three cells fill the send buffer; all three must land in the receive buffer
	task automatic t_cells();
		int c0;
		c0 = cells;
		send_cell(1, 1'b1);
		send_cell(2, 1'b0);
		send_cell(3, 1'b0);
		tick(1);
		check(8'(tx_clav), 8'h00);
		check(8'(tx_led), 8'h01);
		for (int n = 0; n < 12000 && cells < c0 + 3; n++) tick(1);
		check(8'(rx_clav), 8'h01);
		for (int k = 1; k < 4; k++) recv_cell(k);
		tick(2);
		check({6'h00, rx_clav, tx_clav}, 8'h01);
		check(8'(tx_led), 8'h00);
		reg_read(REG_INT_STAT, v);
		check(v & 8'h01, 8'h01);
	endtask

	task automatic t_marker();
		int m0;
		m0 = marks;
		tx_ref = 1'b1;
		tick(3);
		tx_ref = 1'b0;
		tick(600);
		check(8'(marks - m0), 8'h01);
		check(8'(int_line), 8'h00);
		reg_read(REG_INT_STAT, v);
		check(v & 8'h04, 8'h04);
		tick(2);
		check(8'(int_line), 8'h01);
	endtask

	// Stored cell is flushed when the line goes quiet
	task automatic t_loss();
		send_cell(5, 1'b0);
		for (int n = 0; n < 4000 && rx_clav !== 1'b1; n++) tick(1);
		check(8'(rx_clav), 8'h01);
		mute = 1'b1;
		wait_good(1'b0);
		tick(2);
		check(8'(rx_clav), 8'h00);
		reg_read(REG_INT_STAT, v);
		check(v & 8'h02, 8'h02);
		mute = 1'b0;
		wait_good(1'b1);
	endtask

	task automatic t_fast();
		reg_write(REG_CTRL, 8'h01);
		fast = 1'b1;
		reg_read(REG_STATUS, v);
		check(v & 8'h02, 8'h02);
		// Rate change slips the peer's bit phase: force a clean loss and relock
		mute = 1'b1;
		wait_good(1'b0);
		mute = 1'b0;
		wait_good(1'b1);
		send_cell(6, 1'b0);
		for (int n = 0; n < 3000 && rx_clav !== 1'b1; n++) tick(1);
		recv_cell(6);
		reg_write(REG_CTRL, 8'h00);
		ref64 = 1'b1;
		reg_read(REG_STATUS, v);
		check(v & 8'h02, 8'h02);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{ref64, tx_ref, ale, fast, mute, led_q} = '0;
		{cs_n, rd_n, wr_n, tx_enb_n, rx_enb_n, tx_parity} = '1;
		{host_ad, tx_data, tx_addr, rx_addr} = '0;
		{miscompares, comparisons, cyc, marks, cells} = '0;
		tick(6);
		rst_n = 1'b1;
		tick(1);
		t_reset();
		t_regs();
		t_cells();
		t_marker();
		t_loss();
		t_fast();
		test_done();
	end
endmodule // tb_clc_line_coder
